// file: hdl/pfdm_top.sv
// port fault and diagnostic manager for eight ports
// assumes all inputs synchronous to core_clk; controller drains diag_msg
`timescale 1ns/100ps
`include "pfdm_regs.svh"
module pfdm_top #(
  parameter int N_PORTS   = `PFDM_N_PORTS,
  parameter int MAP_N     = `PFDM_MAP_N,
  parameter int MS_CYCLES = `PFDM_MS_CYCLES,
  parameter int RETRY_MS  = `PFDM_RETRY_MS,
  parameter int BLINK_MS  = `PFDM_BLINK_MS
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  // configuration
  input  wire logic [N_PORTS-1:0]            restart_on_reset,
  input  wire logic [N_PORTS-1:0][7:0]       mask_ms,
  input  wire logic                          pull_alarm_en,
  input  wire logic                          port_diag_en,
  input  wire logic                          input_fraction_en,
  // second-channel outputs
  input  wire logic [N_PORTS-1:0]            out_cmd,
  input  wire logic [N_PORTS-1:0]            out_fault,
  output logic      [N_PORTS-1:0]            out_drive,
  // attached devices
  input  wire logic [N_PORTS-1:0]            link_communication_state,
  input  wire logic [N_PORTS-1:0]            dev_present,
  input  wire logic [N_PORTS-1:0]            dev_wrong,
  input  wire logic [N_PORTS-1:0]            cq_short,
  input  wire logic [N_PORTS-1:0][7:0]       cfg_len,
  input  wire logic [N_PORTS-1:0][7:0]       det_len,
  // master conditions
  input  wire logic                          param_invalid,
  input  wire pfdm_pkg::pfdm_map_s [MAP_N-1:0] map_table,
  input  wire logic                          force_active,
  input  wire logic                          internal_fault,
  // indicators and alarms
  output logic      [N_PORTS-1:0]            port_fault_lamp,
  output logic      [N_PORTS-1:0]            link_lamp_green,
  output logic      [N_PORTS-1:0]            pull_alarm,
  // diagnostic stream
  output logic                               diag_valid,
  input  wire logic                          diag_ready,
  output pfdm_pkg::pfdm_diag_s               diag_msg
);

  localparam int N_DIAG = 2 * N_PORTS + `PFDM_N_GLOBAL;
  localparam int G_BASE = 2 * N_PORTS;
  localparam int MS_W   = $clog2(MS_CYCLES + 1);
  localparam int IDX_W  = $clog2(N_DIAG + 1);

  logic [MS_W-1:0]    ms_cnt;
  logic               ms_tick;
  logic [15:0]        blink_cnt;
  logic               blink;
  logic [N_PORTS-1:0] out_rpt;
  logic [N_PORTS-1:0] dev_missing;
  logic [N_PORTS-1:0] link_err;
  logic [N_PORTS-1:0] len_bad;
  logic [N_DIAG-1:0]  diag_act;
  logic [N_DIAG-1:0]  reported;
  logic [IDX_W-1:0]   scan_idx;
  logic [IDX_W-1:0]   msg_idx;

  // duplicate bit position among valid mapping entries
  function automatic logic map_dup(input pfdm_pkg::pfdm_map_s [MAP_N-1:0] tbl);
    logic dup;
    dup = 1'b0;
    for (int i = 0; i < MAP_N; i++) begin
      for (int j = i + 1; j < MAP_N; j++) begin
        if (tbl[i].valid && tbl[j].valid && tbl[i].bit_pos == tbl[j].bit_pos) dup = 1'b1;
      end
    end
    return dup;
  endfunction

  // channel and code of one diagnostic slot
  function automatic pfdm_pkg::pfdm_diag_s diag_desc(input int idx, input logic appear);
    pfdm_pkg::pfdm_diag_s d;
    d.appear  = appear;
    d.channel = `PFDM_CH_GLOBAL;
    d.code    = `PFDM_CODE_INT;
    if (idx < N_PORTS) begin
      d.channel = 16'(idx + 1);
      d.code    = `PFDM_CODE_SHORT;
    end else if (idx < G_BASE) begin
      d.channel = 16'(idx - N_PORTS + 1);
      d.code    = `PFDM_CODE_NODEV;
    end else begin
      case (idx - G_BASE)
        `PFDM_IDX_PARAM: d.code = `PFDM_CODE_PARAM;
        `PFDM_IDX_MAP:   d.code = `PFDM_CODE_MAP;
        `PFDM_IDX_LEN:   d.code = `PFDM_CODE_LEN;
        `PFDM_IDX_SIM:   d.code = `PFDM_CODE_SIM;
        default:         d.code = `PFDM_CODE_INT;
      endcase
    end
    return d;
  endfunction

  // millisecond enable
  always_ff @(posedge core_clk) begin
    if (sys_rst || ms_tick) ms_cnt <= '0;
    else ms_cnt <= ms_cnt + MS_W'(1);
  end
  assign ms_tick = (ms_cnt == MS_W'(MS_CYCLES - 1));

  // indicator blink rate
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      blink_cnt <= 16'h0000;
      blink     <= 1'b0;
    end else if (ms_tick) begin
      if (blink_cnt == 16'(BLINK_MS - 1)) begin
        blink_cnt <= 16'h0000;
        blink     <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 16'h0001;
      end
    end
  end

  for (genvar p = 0; p < N_PORTS; p++) begin : g_port
    pfdm_out_guard #(
      .RETRY_MS (RETRY_MS)
    ) u_guard (
      .core_clk         (core_clk),
      .sys_rst          (sys_rst),
      .ms_tick          (ms_tick),
      .restart_on_reset (restart_on_reset[p]),
      .mask_ms          (mask_ms[p]),
      .out_cmd          (out_cmd[p]),
      .out_fault        (out_fault[p]),
      .out_drive        (out_drive[p]),
      .fault_rpt        (out_rpt[p])
    );
  end

  // attached device errors in communication state
  assign dev_missing = link_communication_state & ~dev_present;
  assign link_err    = link_communication_state & (~dev_present | dev_wrong | cq_short);

  // length check, fraction policy tolerates longer device data
  always_comb begin
    for (int p = 0; p < N_PORTS; p++) begin
      len_bad[p] = link_communication_state[p] & dev_present[p] & ~dev_wrong[p] &
                   (input_fraction_en ? (cfg_len[p] > det_len[p]) : (cfg_len[p] != det_len[p]));
    end
  end

  // active diagnostic set, follows causes both ways
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      diag_act <= '0;
    end else begin
      diag_act[N_PORTS-1:0]                <= out_rpt;
      // no device slots when pull alarm is on or port diagnostics are off
      diag_act[G_BASE-1:N_PORTS]           <= link_err & {N_PORTS{~pull_alarm_en & port_diag_en}};
      diag_act[G_BASE + `PFDM_IDX_PARAM]   <= param_invalid;
      diag_act[G_BASE + `PFDM_IDX_MAP]     <= map_dup(map_table);
      diag_act[G_BASE + `PFDM_IDX_LEN]     <= |len_bad;
      diag_act[G_BASE + `PFDM_IDX_SIM]     <= force_active;
      diag_act[G_BASE + `PFDM_IDX_INT]     <= internal_fault;
    end
  end

  // report each appear and withdraw as a message
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reported   <= '0;
      scan_idx   <= '0;
      msg_idx    <= '0;
      diag_valid <= 1'b0;
      diag_msg   <= '0;
    end else if (diag_valid) begin
      if (diag_ready) begin
        reported[msg_idx] <= diag_msg.appear;
        diag_valid        <= 1'b0;
      end
    end else begin
      if (diag_act[scan_idx] != reported[scan_idx]) begin
        diag_valid <= 1'b1;
        msg_idx    <= scan_idx;
        diag_msg   <= diag_desc(int'(scan_idx), diag_act[scan_idx]);
      end
      scan_idx <= (scan_idx == IDX_W'(N_DIAG - 1)) ? '0 : scan_idx + IDX_W'(1);
    end
  end

  // lamps and pull alarms
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_fault_lamp <= '0;
      link_lamp_green <= '0;
      pull_alarm      <= '0;
    end else begin
      // red on output fault or wrong or shorted device, kept off while missing
      port_fault_lamp <= ~dev_missing & (out_rpt | (link_err & ~dev_missing));
      link_lamp_green <= (dev_missing & {N_PORTS{blink}}) |
                         (link_communication_state & dev_present & ~link_err);
      // pull alarm for missing or faulty device
      pull_alarm      <= link_err & {N_PORTS{pull_alarm_en}};
    end
  end

  sequence s_missing;
    dev_missing[2] && !out_rpt[2];
  endsequence
  sequence s_lamps_missing;
    !port_fault_lamp[2] && link_lamp_green[2] == $past(blink);
  endsequence

  property p_red_lamp;
    @(posedge core_clk) disable iff (sys_rst)
    (out_rpt[0] && !dev_missing[0]) |=> port_fault_lamp[0];
  endproperty
  a_red_lamp: assert property (p_red_lamp) else $error("red lamp not lit");

  property p_link_err;
    @(posedge core_clk) disable iff (sys_rst)
    (link_communication_state[2] && dev_present[2] && (dev_wrong[2] || cq_short[2]))
      |=> port_fault_lamp[2];
  endproperty
  a_link_err: assert property (p_link_err) else $error("link error missed");

  property p_pull;
    @(posedge core_clk) disable iff (sys_rst)
    (pull_alarm_en && link_err[2]) |=> pull_alarm[2] && !diag_act[N_PORTS + 2];
  endproperty
  a_pull: assert property (p_pull) else $error("pull alarm missing");

  property p_nodev;
    @(posedge core_clk) disable iff (sys_rst)
    (!pull_alarm_en && port_diag_en && link_err[2]) |=> diag_act[N_PORTS + 2] && !pull_alarm[2];
  endproperty
  a_nodev: assert property (p_nodev) else $error("no device diagnostic missing");

  property p_missing_lamps;
    @(posedge core_clk) disable iff (sys_rst)
    s_missing |=> s_lamps_missing;
  endproperty
  a_missing_lamps: assert property (p_missing_lamps) else $error("missing lamps wrong");

  property p_param;
    @(posedge core_clk) disable iff (sys_rst)
    param_invalid |=> diag_act[G_BASE + `PFDM_IDX_PARAM];
  endproperty
  a_param: assert property (p_param) else $error("parameter diagnostic missing");

  property p_map;
    @(posedge core_clk) disable iff (sys_rst)
    (map_table[2].valid && map_table[3].valid && map_table[2].bit_pos == map_table[3].bit_pos)
      |=> diag_act[G_BASE + `PFDM_IDX_MAP];
  endproperty
  a_map: assert property (p_map) else $error("mapping fault missed");

  property p_len;
    @(posedge core_clk) disable iff (sys_rst)
    (len_bad[4]) |=> diag_act[G_BASE + `PFDM_IDX_LEN];
  endproperty
  a_len: assert property (p_len) else $error("length mismatch missed");

  property p_sim_msg;
    @(posedge core_clk) disable iff (sys_rst)
    (diag_valid && msg_idx == IDX_W'(G_BASE + `PFDM_IDX_SIM))
      |-> diag_msg.channel == `PFDM_CH_GLOBAL && diag_msg.code == `PFDM_CODE_SIM;
  endproperty
  a_sim_msg: assert property (p_sim_msg) else $error("simulation message wrong");

  property p_int;
    @(posedge core_clk) disable iff (sys_rst)
    internal_fault ##1 internal_fault |-> diag_act[G_BASE + `PFDM_IDX_INT];
  endproperty
  a_int: assert property (p_int) else $error("internal error missed");

  property p_short_msg;
    @(posedge core_clk) disable iff (sys_rst)
    (diag_valid && msg_idx == IDX_W'(5))
      |-> diag_msg.channel == 16'h0006 && diag_msg.code == `PFDM_CODE_SHORT;
  endproperty
  a_short_msg: assert property (p_short_msg) else $error("short message wrong");

  property p_withdraw;
    @(posedge core_clk) disable iff (sys_rst)
    (diag_valid && diag_ready) |=> reported[$past(msg_idx)] == $past(diag_msg.appear);
  endproperty
  a_withdraw: assert property (p_withdraw) else $error("report set not updated");

  property p_red_clear;
    @(posedge core_clk) disable iff (sys_rst)
    (!out_rpt[0] && !link_err[0]) |=> !port_fault_lamp[0];
  endproperty
  a_red_clear: assert property (p_red_clear) else $error("red lamp not withdrawn");

  property p_param_clear;
    @(posedge core_clk) disable iff (sys_rst)
    !param_invalid |=> !diag_act[G_BASE + `PFDM_IDX_PARAM];
  endproperty
  a_param_clear: assert property (p_param_clear) else $error("parameter diagnostic kept");

endmodule // pfdm_top

// file: pkg/pfdm_regs.svh
// constants of the port fault and diagnostic manager
// assumes a single 200 MHz core clock and a synchronous reset
`ifndef PFDM_REGS_SVH
`define PFDM_REGS_SVH

`define PFDM_N_PORTS      8
`define PFDM_MAP_N        16
`define PFDM_CLK_NS       5
`define PFDM_TICK_NS      1000000
`define PFDM_MS_CYCLES    (`PFDM_TICK_NS / `PFDM_CLK_NS)
`define PFDM_MASK_MS_RST  8'h50
`define PFDM_RETRY_MS     100
`define PFDM_BLINK_MS     250

`define PFDM_CH_GLOBAL    16'h8000
`define PFDM_CODE_SHORT   16'h1810
`define PFDM_CODE_NODEV   16'h1800
`define PFDM_CODE_PARAM   16'h0010
`define PFDM_CODE_MAP     16'h011A
`define PFDM_CODE_LEN     16'h17FF
`define PFDM_CODE_SIM     16'h000A
`define PFDM_CODE_INT     16'h0009

// diagnostic slot indices after the two per-port groups
`define PFDM_IDX_PARAM    0
`define PFDM_IDX_MAP      1
`define PFDM_IDX_LEN      2
`define PFDM_IDX_SIM      3
`define PFDM_IDX_INT      4
`define PFDM_N_GLOBAL     5

`endif

// file: pkg/pfdm_pkg.sv
// types of the port fault and diagnostic manager
// used by the output guard and the top module
package pfdm_pkg;

  typedef enum logic [2:0] {
    G_IDLE = 3'b001,
    G_ON   = 3'b010,
    G_TRIP = 3'b100
  } pfdm_guard_e;

  typedef struct packed {
    logic       valid;
    logic [5:0] bit_pos;
  } pfdm_map_s;

  typedef struct packed {
    logic        appear;
    logic [15:0] channel;
    logic [15:0] code;
  } pfdm_diag_s;

endpackage

// file: hdl/pfdm_out_guard.sv
// one second-channel output: protection, restart policy, turn-on masking
// assumes a one-cycle ms_tick from the top's divider
`timescale 1ns/100ps
`include "pfdm_regs.svh"
module pfdm_out_guard #(
  parameter int RETRY_MS = `PFDM_RETRY_MS
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       ms_tick,
  // configuration
  input  wire logic       restart_on_reset,
  input  wire logic [7:0] mask_ms,
  // channel
  input  wire logic       out_cmd,
  input  wire logic       out_fault,
  output logic            out_drive,
  output logic            fault_rpt
);

  pfdm_pkg::pfdm_guard_e state;
  pfdm_pkg::pfdm_guard_e next_state;
  logic                  drive_prev;
  logic [8:0]            mask_cnt;
  logic [15:0]           retry_cnt;
  logic                  rise;
  logic                  fault_seen;
  logic                  retry_done;

  assign rise       = out_drive & ~drive_prev;
  assign fault_seen = out_drive & out_fault & (mask_cnt == 9'h000) & ~rise;
  assign retry_done = ms_tick & (retry_cnt == 16'(RETRY_MS - 1));

  always_comb begin
    next_state = state;
    case (state)
      pfdm_pkg::G_IDLE: begin
        if (out_cmd) next_state = pfdm_pkg::G_ON;
      end
      pfdm_pkg::G_ON: begin
        if (!out_cmd) next_state = pfdm_pkg::G_IDLE;
        else if (fault_seen) next_state = pfdm_pkg::G_TRIP;
      end
      pfdm_pkg::G_TRIP: begin
        if (!out_cmd) next_state = pfdm_pkg::G_IDLE;
        else if (!restart_on_reset && retry_done) next_state = pfdm_pkg::G_ON;
      end
      default: next_state = pfdm_pkg::G_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state      <= pfdm_pkg::G_IDLE;
      out_drive  <= 1'b0;
      drive_prev <= 1'b0;
    end else begin
      state      <= next_state;
      out_drive  <= (next_state == pfdm_pkg::G_ON);
      drive_prev <= out_drive;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) mask_cnt <= 9'h000;
    else if (rise) mask_cnt <= {1'b0, mask_ms} + {8'h00, (mask_ms != 8'h00)};
    else if (ms_tick && mask_cnt != 9'h000) mask_cnt <= mask_cnt - 9'h001;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || state != pfdm_pkg::G_TRIP) retry_cnt <= 16'h0000;
    else if (retry_done) retry_cnt <= 16'h0000;
    else if (ms_tick) retry_cnt <= retry_cnt + 16'h0001;
  end

  // short report, set wins, withdrawn when idle or once clean while on
  always_ff @(posedge core_clk) begin
    if (sys_rst) fault_rpt <= 1'b0;
    else if (state == pfdm_pkg::G_ON && fault_seen) fault_rpt <= 1'b1;
    else if (state == pfdm_pkg::G_IDLE) fault_rpt <= 1'b0;
    else if (state == pfdm_pkg::G_ON && mask_cnt == 9'h000 && !out_fault && !rise)
      fault_rpt <= 1'b0;
  end

  property p_trip_off;
    @(posedge core_clk) disable iff (sys_rst)
    (state == pfdm_pkg::G_ON && out_cmd && fault_seen) |=> !out_drive ##1 !out_drive;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("output not forced off");

  property p_auto_retry;
    @(posedge core_clk) disable iff (sys_rst)
    (state == pfdm_pkg::G_TRIP && out_cmd && !restart_on_reset && retry_done) |=> out_drive;
  endproperty
  a_auto_retry: assert property (p_auto_retry) else $error("no automatic restart");

  property p_hold_off;
    @(posedge core_clk) disable iff (sys_rst)
    (state == pfdm_pkg::G_TRIP && restart_on_reset && out_cmd) |=> !out_drive;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("restarted without reset");

  property p_mask_load;
    @(posedge core_clk) disable iff (sys_rst)
    (rise && mask_ms != 8'h00) |=> (mask_cnt == {1'b0, $past(mask_ms)} + 9'h001);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

  property p_mask_quiet;
    @(posedge core_clk) disable iff (sys_rst)
    (mask_cnt != 9'h000) |-> !fault_seen;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("fault seen in mask");

  property p_rpt_set;
    @(posedge core_clk) disable iff (sys_rst)
    (state == pfdm_pkg::G_ON && fault_seen) |=> fault_rpt;
  endproperty
  a_rpt_set: assert property (p_rpt_set) else $error("short not reported");

endmodule // pfdm_out_guard

// file: testbench/pfdm_ctrl_model.sv
// controller model: takes diagnostic messages from the manager
// assumes stall from the bench; taken messages kept in arrival order
`timescale 1ns/100ps
module pfdm_ctrl_model (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // pacing of acceptance
  input  wire logic [3:0]           stall,
  // diagnostic stream
  input  wire logic                 diag_valid,
  input  wire pfdm_pkg::pfdm_diag_s diag_msg,
  output logic                      diag_ready
);
  logic [3:0]           wait_cnt;
  pfdm_pkg::pfdm_diag_s msg_q[$];

  initial diag_ready = 1'b0;

  // ready only answers a pending message, so a stall really holds it
  always @(posedge core_clk) begin
    if (sys_rst) begin
      diag_ready <= 1'b0;
      wait_cnt   <= 4'h0;
      msg_q.delete();
    end else if (diag_valid && diag_ready) begin
      msg_q.push_back(diag_msg);
      diag_ready <= 1'b0;
      wait_cnt   <= 4'h0;
    end else if (diag_valid && wait_cnt >= stall) begin
      diag_ready <= 1'b1;
    end else if (diag_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // pfdm_ctrl_model

// file: testbench/pfdm_top_test.sv
// self-checking bench of the port fault and diagnostic manager
// assumes shortened ms tick, retry and blink counts; model drains diagnostics
`timescale 1ns/100ps
module pfdm_top_test;
  localparam int          MS       = 20;
  localparam int          RETRY    = 2;
  localparam int          BLINK    = 2;
  localparam logic [15:0] GCODE[5] = '{16'h0010, 16'h011A, 16'h17FF, 16'h000A, 16'h0009};

  logic                       core_clk, sys_rst, pull_alarm_en, port_diag_en;
  logic                       input_fraction_en, param_invalid, force_active;
  logic                       internal_fault, diag_valid, diag_ready;
  logic [7:0]                 restart_on_reset, out_cmd, out_fault, out_drive;
  logic [7:0]                 link_communication_state, dev_present, dev_wrong, cq_short;
  logic [7:0]                 port_fault_lamp, link_lamp_green, pull_alarm;
  logic [7:0][7:0]            mask_ms, cfg_len, det_len;
  pfdm_pkg::pfdm_map_s [15:0] map_table;
  pfdm_pkg::pfdm_diag_s       diag_msg;
  logic [3:0]                 stall;
  logic [1:0]                 blink_seen;
  int                         fail_count;
  int                         samples_checked;

  pfdm_top #(.MS_CYCLES(MS), .RETRY_MS(RETRY), .BLINK_MS(BLINK)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .restart_on_reset(restart_on_reset),
    .mask_ms(mask_ms), .pull_alarm_en(pull_alarm_en), .port_diag_en(port_diag_en),
    .input_fraction_en(input_fraction_en), .out_cmd(out_cmd), .out_fault(out_fault),
    .out_drive(out_drive), .link_communication_state(link_communication_state),
    .dev_present(dev_present), .dev_wrong(dev_wrong), .cq_short(cq_short),
    .cfg_len(cfg_len), .det_len(det_len), .param_invalid(param_invalid),
    .map_table(map_table), .force_active(force_active), .internal_fault(internal_fault),
    .port_fault_lamp(port_fault_lamp), .link_lamp_green(link_lamp_green),
    .pull_alarm(pull_alarm), .diag_valid(diag_valid), .diag_ready(diag_ready),
    .diag_msg(diag_msg));

  pfdm_ctrl_model ctrl_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .stall(stall), .diag_valid(diag_valid),
    .diag_msg(diag_msg), .diag_ready(diag_ready));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic results();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic check1(input string what, input logic seen, input logic exp);
    check(what, 64'(seen), 64'(exp));
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic timeout(input string what);
    fail_count++;
    $display("[FAIL] %s expected event seen none", what);
    results();
  endtask

  task automatic expect_msg(input logic ap, input logic [15:0] ch, input logic [15:0] code);
    pfdm_pkg::pfdm_diag_s got;
    for (int i = 0; i < 400 && ctrl_u.msg_q.size() == 0; i++) cyc(1);
    if (ctrl_u.msg_q.size() == 0) begin
      timeout("diag_msg");
    end else begin
      got = ctrl_u.msg_q.pop_front();
      check("diag_msg", 64'(got), 64'({ap, ch, code}));
    end
  endtask

  task automatic no_msg(input int n);
    cyc(n);
    check("diag_quiet", 64'(ctrl_u.msg_q.size()), 64'h0);
  endtask

  task automatic wait_drive(input int p, input logic lvl, input int bound);
    for (int i = 0; i < bound && out_drive[p] !== lvl; i++) cyc(1);
    if (out_drive[p] !== lvl) timeout("out_drive");
  endtask

  task automatic set_global(input int k, input logic v);
    case (k)
      0: param_invalid = v;
      1: map_table[3].valid = v;
      2: cfg_len[4] = v ? 8'h04 : 8'h02;
      3: force_active = v;
      default: internal_fault = v;
    endcase
  endtask

  initial begin
    fail_count = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    restart_on_reset = 8'h02;
    mask_ms = {8{8'h50}};
    mask_ms[0] = 8'h03;
    mask_ms[1] = 8'h00;
    pull_alarm_en = 1'b1;
    port_diag_en = 1'b1;
    input_fraction_en = 1'b0;
    out_cmd = 8'h00;
    out_fault = 8'h00;
    link_communication_state = 8'h10;
    dev_present = 8'h10;
    dev_wrong = 8'h00;
    cq_short = 8'h00;
    cfg_len = {8{8'h02}};
    det_len = {8{8'h02}};
    param_invalid = 1'b0;
    map_table = '0;
    map_table[2] = {1'b1, 6'h05};
    map_table[3].bit_pos = 6'h05;
    force_active = 1'b0;
    internal_fault = 1'b0;
    stall = 4'h0;
    blink_seen = 2'b00;
    cyc(20);
    sys_rst = 1'b0;
    cyc(2);
    check("out_drive", 64'(out_drive), 64'h0);
    check1("diag_valid", diag_valid, 1'b0);
    check1("green4", link_lamp_green[4], 1'b1);
    // auto policy with short mask on port 1
    out_cmd[0] = 1'b1;
    cyc(2);
    check1("out_drive0", out_drive[0], 1'b1);
    out_fault[0] = 1'b1;
    cyc(50);
    check1("out_drive0", out_drive[0], 1'b1);
    no_msg(0);
    wait_drive(0, 1'b0, 60);
    expect_msg(1'b1, 16'h0001, 16'h1810);
    check1("red0", port_fault_lamp[0], 1'b1);
    wait_drive(0, 1'b1, RETRY * MS + 30);
    wait_drive(0, 1'b0, 5 * MS);
    out_fault[0] = 1'b0;
    out_cmd[0] = 1'b0;
    expect_msg(1'b0, 16'h0001, 16'h1810);
    cyc(2);
    check1("red0", port_fault_lamp[0], 1'b0);
    // reset policy on port 2, no mask
    out_cmd[1] = 1'b1;
    cyc(2);
    out_fault[1] = 1'b1;
    wait_drive(1, 1'b0, 5);
    expect_msg(1'b1, 16'h0002, 16'h1810);
    out_fault[1] = 1'b0;
    cyc(5 * MS);
    check1("out_drive1", out_drive[1], 1'b0);
    out_cmd[1] = 1'b0;
    expect_msg(1'b0, 16'h0002, 16'h1810);
    out_cmd[1] = 1'b1;
    cyc(2);
    check1("out_drive1", out_drive[1], 1'b1);
    out_cmd[1] = 1'b0;
    // default turn-on mask on port 6
    out_cmd[5] = 1'b1;
    out_fault[5] = 1'b1;
    cyc(80 * MS - 20);
    check1("out_drive5", out_drive[5], 1'b1);
    wait_drive(5, 1'b0, 3 * MS);
    expect_msg(1'b1, 16'h0006, 16'h1810);
    out_cmd[5] = 1'b0;
    out_fault[5] = 1'b0;
    expect_msg(1'b0, 16'h0006, 16'h1810);
    // missing device on port 3 with pull alarm enabled
    link_communication_state[2] = 1'b1;
    cyc(3);
    check1("pull_alarm2", pull_alarm[2], 1'b1);
    check1("red2", port_fault_lamp[2], 1'b0);
    for (int i = 0; i < 4 * BLINK * MS; i++) begin
      if (link_lamp_green[2] === 1'b1) blink_seen[1] = 1'b1;
      if (link_lamp_green[2] === 1'b0) blink_seen[0] = 1'b1;
      cyc(1);
    end
    check("blink2", 64'(blink_seen), 64'h3);
    no_msg(0);
    dev_present[2] = 1'b1;
    for (int j = 0; j < 2; j++) begin
      dev_wrong[2] = (j == 0);
      cq_short[2] = (j == 1);
      cyc(3);
      check1("pull_alarm2", pull_alarm[2], 1'b1);
      check1("red2", port_fault_lamp[2], 1'b1);
      dev_wrong[2] = 1'b0;
      cq_short[2] = 1'b0;
      cyc(3);
      check1("pull_alarm2", pull_alarm[2], 1'b0);
    end
    // pull alarm and port diagnostics both off: nothing reported
    pull_alarm_en = 1'b0;
    port_diag_en = 1'b0;
    dev_present[2] = 1'b0;
    no_msg(80);
    check1("pull_alarm2", pull_alarm[2], 1'b0);
    // port diagnostics on: channel diagnostic instead
    port_diag_en = 1'b1;
    expect_msg(1'b1, 16'h0003, 16'h1800);
    dev_present[2] = 1'b1;
    expect_msg(1'b0, 16'h0003, 16'h1800);
    // input fraction: shorter configured length is accepted
    input_fraction_en = 1'b1;
    det_len[4] = 8'h04;
    no_msg(80);
    det_len[4] = 8'h02;
    input_fraction_en = 1'b0;
    // global diagnostics with a slow controller
    stall = 4'h5;
    for (int k = 0; k < 5; k++) begin
      set_global(k, 1'b1);
      expect_msg(1'b1, 16'h8000, GCODE[k]);
      set_global(k, 1'b0);
      expect_msg(1'b0, 16'h8000, GCODE[k]);
    end
    no_msg(60);
    results();
  end
endmodule // pfdm_top_test
